// ---- opdec_pkg.sv ----
package opdec_pkg;

  // ********************************************************
  // register map of the decode control port
  // ********************************************************
  localparam logic [7:0]  ctrl_offset        = 8'h00;
  localparam logic [7:0]  status_offset      = 8'h04;
  localparam logic [7:0]  count_offset       = 8'h08;
  localparam int          ctrl_size_bit      = 0;
  localparam int          ctrl_legacy_bit    = 1;
  localparam int          status_op32_bit    = 0;
  localparam int          status_addr32_bit  = 1;
  localparam int          status_bad_seg_bit = 2;
  localparam logic        ctrl_size_reset    = 1'h0;
  localparam logic        ctrl_legacy_reset  = 1'h0;
  localparam logic [31:0] count_reset        = 32'h0;

  // ********************************************************
  // addressing byte fields and special codes
  // ********************************************************
  localparam int         mod_lsb        = 6;
  localparam int         reg_lsb        = 3;
  localparam int         rm_lsb         = 0;
  localparam logic [1:0] mod_no_disp    = 2'h0;
  localparam logic [1:0] mod_short_disp = 2'h1;
  localparam logic [1:0] mod_word_disp  = 2'h2;
  localparam logic [1:0] mod_register   = 2'h3;
  localparam logic [2:0] rm_sib_escape  = 3'h4;
  localparam logic [2:0] rm_direct16    = 3'h6;
  localparam logic [2:0] rm_direct32    = 3'h5;
  localparam logic [2:0] index_none     = 3'h4;
  localparam logic [2:0] base_stack     = 3'h4;
  localparam logic [2:0] base_frame     = 3'h5;
  localparam logic [2:0] seg3_last_good = 3'h5;

  // ********************************************************
  // register, segment and displacement names
  // ********************************************************
  typedef enum logic [4:0] {
    gpr_none,
    accumulator_low_byte, count_low_byte, data_low_byte, base_low_byte,
    accumulator_high_byte, count_high_byte, data_high_byte,
    base_high_byte,
    accumulator_word, count_word, data_word, base_word,
    stack_pointer_word, frame_pointer_word, source_index_word,
    dest_index_word,
    accumulator_dword, count_dword, data_dword, base_dword,
    stack_pointer_dword, frame_pointer_dword, source_index_dword,
    dest_index_dword
  } gpr_t;

  localparam logic [4:0] byte_first  = 5'h01;
  localparam logic [4:0] word_first  = 5'h09;
  localparam logic [4:0] dword_first = 5'h11;

  typedef enum logic [2:0] {
    seg_none, extra_segment, code_segment, stack_segment, data_segment,
    third_extra_segment, fourth_extra_segment
  } seg_t;

  typedef enum logic [1:0] {
    no_displacement, short_displacement, word_displacement,
    dword_displacement
  } disp_t;

  // ********************************************************
  // decode request and result carriers
  // ********************************************************
  typedef struct packed {
    logic       implied_addr;   // push/pop style, no addressing byte
    logic       reg_is_ext;     // middle modrm bits extend the opcode
    logic       gpr_from_opcode;// selector sits in the opcode byte
    logic [2:0] gpr_field;      // selector from the opcode byte
    logic       w_present;
    logic       w;              // operand_size_bit
    logic       opsize_prefix;
    logic       addrsize_prefix;
    logic [1:0] seg_sel_2bit;
    logic [2:0] seg_sel_3bit;
    logic [7:0] modrm;
    logic [7:0] sib;
  } dec_req_t;

  typedef struct packed {
    logic       op32;
    logic       addr32;
    gpr_t       operand_reg;
    logic [2:0] opcode_ext;
    logic       rm_is_reg;
    gpr_t       rm_reg;
    logic       sib_expected;
    gpr_t       base_reg;
    gpr_t       index_reg;
    logic [1:0] scale;
    disp_t      disp;
    seg_t       def_seg;
    seg_t       seg2;
    seg_t       seg3;
    logic       bad_seg;
  } dec_result_t;

endpackage

// ---- gpr_field_decoder.sv ----
`timescale 1ns/1ns
module gpr_field_decoder (
  // selector and size context
  input  wire logic        i_w_present,
  input  wire logic        i_w,
  input  wire logic        i_op32,
  input  wire logic [2:0]  i_code,
  // selected register
  output opdec_pkg::gpr_t  o_reg
);

  logic [4:0] first;

  // ********************************************************
  // byte, word or doubleword bank, then the code within it
  // ********************************************************
  always_comb begin
    if (i_w_present && !i_w) begin
      first = opdec_pkg::byte_first;
    end else if (i_op32) begin
      first = opdec_pkg::dword_first;
    end else begin
      first = opdec_pkg::word_first;
    end
    o_reg = opdec_pkg::gpr_t'(5'(first + {2'h0, i_code}));
  end

endmodule

// ---- operand_addr_field_decoder.sv ----
// Contract
// - no size bit: codes 000-111 pick word or dword registers by size
// - size bit zero: codes pick the eight byte registers in order
// - size bit one: codes pick full registers, same order as
// - 2-bit segment field: extra, code, stack, data
// - 3-bit segment field adds third and fourth extra; 110/111 reserved
// - addressing comes from addressing bytes unless implied by opcode
// - sib byte expected only in 32-bit addressing, rm 100, mod not 11
// - with sib, mode from mod plus scale, index and base fields
// - modrm middle bits are opcode extension or register selector
// - addressing byte read as 16-bit or 32-bit form by address size
// - 16-bit mod 00 table; frame pointer forms use stack segment
// - mod 01/10 add byte or word displacement; rm 110 is frame+disp
// - mod 11 makes the operand a register, same order as selector
// - size prefixes flip operand or address size for one instruction
// - real and virtual 8086 modes take default size as 16 bits
// - size bit zero means byte operand, one means full size
`timescale 1ns/1ns
module operand_addr_field_decoder (
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  // register port
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [31:0]                 o_rdata,
  // decode request
  input  wire logic                   i_req_valid,
  input  wire opdec_pkg::dec_req_t    i_req,
  // decode result, one cycle later
  output logic                        o_res_valid,
  output opdec_pkg::dec_result_t      o_res
);

  // ********************************************************
  // state of the block
  // ********************************************************
  typedef struct packed {
    logic                   default_size;  // code segment default bit
    logic                   legacy_mode;   // real or virtual 8086 mode
    logic                   bad_seg_seen;  // sticky, write one clears
    logic [31:0]            count;         // decodes done
    logic [31:0]            rdata;
    logic                   res_valid;
    opdec_pkg::dec_result_t res;
  } state_t;

  state_t state;
  state_t next_state;

  // ********************************************************
  // helper functions
  // ********************************************************
  // 2-bit segment code; the 3-bit form reuses it for its low half
  function automatic opdec_pkg::seg_t seg_from_2bit(input logic [1:0] c);
    case (c)
      2'h0:    seg_from_2bit = opdec_pkg::extra_segment;
      2'h1:    seg_from_2bit = opdec_pkg::code_segment;
      2'h2:    seg_from_2bit = opdec_pkg::stack_segment;
      default: seg_from_2bit = opdec_pkg::data_segment;
    endcase
  endfunction

  function automatic opdec_pkg::gpr_t dword_reg(input logic [2:0] c);
    dword_reg = opdec_pkg::gpr_t'(5'(opdec_pkg::dword_first + {2'h0, c}));
  endfunction

  function automatic opdec_pkg::gpr_t word_reg(input logic [2:0] c);
    word_reg = opdec_pkg::gpr_t'(5'(opdec_pkg::word_first + {2'h0, c}));
  endfunction

  // ********************************************************
  // effective sizes and field split
  // ********************************************************
  logic       eff_default;
  logic       op32;
  logic       addr32;
  logic [1:0] mod_f;
  logic [2:0] reg_f;
  logic [2:0] rm_f;
  logic [1:0] ss_f;
  logic [2:0] idx_f;
  logic [2:0] base_f;
  logic [2:0] sel_code;
  opdec_pkg::gpr_t sel_reg;
  opdec_pkg::gpr_t rm_reg;

  // legacy modes force the default bit low; prefixes invert it
  always_comb begin
    eff_default = state.default_size & ~state.legacy_mode;
    op32        = eff_default ^ i_req.opsize_prefix;
    addr32      = eff_default ^ i_req.addrsize_prefix;
    mod_f  = i_req.modrm[opdec_pkg::mod_lsb +: 2];
    reg_f  = i_req.modrm[opdec_pkg::reg_lsb +: 3];
    rm_f   = i_req.modrm[opdec_pkg::rm_lsb +: 3];
    ss_f   = i_req.sib[opdec_pkg::mod_lsb +: 2];
    idx_f  = i_req.sib[opdec_pkg::reg_lsb +: 3];
    base_f = i_req.sib[opdec_pkg::rm_lsb +: 3];
    sel_code = i_req.gpr_from_opcode ? i_req.gpr_field : reg_f;
  end

  // ********************************************************
  // register selector and register-direct operand
  // ********************************************************
  gpr_field_decoder u_sel_dec (
    .i_w_present (i_req.w_present),
    .i_w         (i_req.w),
    .i_op32      (op32),
    .i_code      (sel_code),
    .o_reg       (sel_reg)
  );

  // mod 11 uses the selector's size bit context; absent bit means full size
  gpr_field_decoder u_rm_dec (
    .i_w_present (i_req.w_present),
    .i_w         (i_req.w),
    .i_op32      (op32),
    .i_code      (rm_f),
    .o_reg       (rm_reg)
  );

  // ********************************************************
  // addressing mode decode
  // ********************************************************
  opdec_pkg::dec_result_t dec;

  always_comb begin
    dec = '0;
    dec.op32   = op32;
    dec.addr32 = addr32;
    dec.disp   = opdec_pkg::no_displacement;
    dec.def_seg = opdec_pkg::seg_none;
    dec.base_reg  = opdec_pkg::gpr_none;
    dec.index_reg = opdec_pkg::gpr_none;
    dec.rm_reg    = opdec_pkg::gpr_none;
    // middle bits: opcode extension or register
    if (i_req.reg_is_ext && !i_req.gpr_from_opcode) begin
      dec.opcode_ext  = reg_f;
      dec.operand_reg = opdec_pkg::gpr_none;
    end else begin
      dec.opcode_ext  = 3'h0;
      dec.operand_reg = sel_reg;
    end
    // segment selector fields
    dec.seg2 = seg_from_2bit(i_req.seg_sel_2bit);
    if (!i_req.seg_sel_3bit[2]) begin
      dec.seg3 = seg_from_2bit(i_req.seg_sel_3bit[1:0]);
    end else if (i_req.seg_sel_3bit[0]) begin
      dec.seg3 = opdec_pkg::fourth_extra_segment;
    end else begin
      dec.seg3 = opdec_pkg::third_extra_segment;
    end
    // reserved codes select nothing and are flagged
    if (i_req.seg_sel_3bit > opdec_pkg::seg3_last_good) begin
      dec.seg3    = opdec_pkg::seg_none;
      dec.bad_seg = 1'b1;
    end
    if (i_req.implied_addr) begin
      // addressing fixed by the opcode: no addressing byte is read
      dec.rm_is_reg = 1'b0;
    end else if (mod_f == opdec_pkg::mod_register) begin
      dec.rm_is_reg = 1'b1;
      dec.rm_reg    = rm_reg;
    end else if (!addr32) begin
      // 16-bit form
      dec.def_seg = opdec_pkg::data_segment;
      case (rm_f)
        3'h0: begin
          dec.base_reg  = opdec_pkg::base_word;
          dec.index_reg = opdec_pkg::source_index_word;
        end
        3'h1: begin
          dec.base_reg  = opdec_pkg::base_word;
          dec.index_reg = opdec_pkg::dest_index_word;
        end
        3'h2: begin
          dec.base_reg  = opdec_pkg::frame_pointer_word;
          dec.index_reg = opdec_pkg::source_index_word;
          dec.def_seg   = opdec_pkg::stack_segment;
        end
        3'h3: begin
          dec.base_reg  = opdec_pkg::frame_pointer_word;
          dec.index_reg = opdec_pkg::dest_index_word;
          dec.def_seg   = opdec_pkg::stack_segment;
        end
        3'h4: dec.index_reg = opdec_pkg::source_index_word;
        3'h5: dec.index_reg = opdec_pkg::dest_index_word;
        3'h6: begin
          if (mod_f != opdec_pkg::mod_no_disp) begin
            dec.base_reg = opdec_pkg::frame_pointer_word;
            dec.def_seg  = opdec_pkg::stack_segment;
          end
        end
        default: dec.base_reg = opdec_pkg::base_word;
      endcase
      case (mod_f)
        opdec_pkg::mod_short_disp:
          dec.disp = opdec_pkg::short_displacement;
        opdec_pkg::mod_word_disp:
          dec.disp = opdec_pkg::word_displacement;
        default: begin
          if (rm_f == opdec_pkg::rm_direct16) begin
            dec.disp = opdec_pkg::word_displacement;
          end
        end
      endcase
    end else begin
      // 32-bit form
      dec.def_seg = opdec_pkg::data_segment;
      case (mod_f)
        opdec_pkg::mod_short_disp:
          dec.disp = opdec_pkg::short_displacement;
        opdec_pkg::mod_word_disp:
          dec.disp = opdec_pkg::dword_displacement;
        default: dec.disp = opdec_pkg::no_displacement;
      endcase
      if (rm_f == opdec_pkg::rm_sib_escape) begin
        dec.sib_expected = 1'b1;
        dec.scale = ss_f;
        // scale with index 100 is left to software to keep at 00
        if (idx_f != opdec_pkg::index_none) begin
          dec.index_reg = dword_reg(idx_f);
        end
        if (mod_f == opdec_pkg::mod_no_disp &&
            base_f == opdec_pkg::base_frame) begin
          dec.disp = opdec_pkg::dword_displacement;
        end else begin
          dec.base_reg = dword_reg(base_f);
          if (base_f == opdec_pkg::base_stack ||
              base_f == opdec_pkg::base_frame) begin
            dec.def_seg = opdec_pkg::stack_segment;
          end
        end
      end else if (mod_f == opdec_pkg::mod_no_disp &&
                   rm_f == opdec_pkg::rm_direct32) begin
        dec.disp = opdec_pkg::dword_displacement;
      end else begin
        dec.base_reg = dword_reg(rm_f);
        if (rm_f == opdec_pkg::base_frame) begin
          dec.def_seg = opdec_pkg::stack_segment;
        end
      end
    end
  end

  // ********************************************************
  // next state: register port and result capture
  // ********************************************************
  always_comb begin
    next_state = state;
    next_state.res_valid = i_req_valid;
    if (i_req_valid) begin
      next_state.res   = dec;
      next_state.count = state.count + 32'h1;
    end
    if (i_wr && i_addr == opdec_pkg::ctrl_offset) begin
      next_state.default_size = i_wdata[opdec_pkg::ctrl_size_bit];
      next_state.legacy_mode  = i_wdata[opdec_pkg::ctrl_legacy_bit];
    end
    if (i_wr && i_addr == opdec_pkg::status_offset &&
        i_wdata[opdec_pkg::status_bad_seg_bit]) begin
      next_state.bad_seg_seen = 1'b0;
    end
    // a fresh bad code in the clearing cycle is kept: set wins
    if (i_req_valid && dec.bad_seg) begin
      next_state.bad_seg_seen = 1'b1;
    end
    next_state.rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        opdec_pkg::ctrl_offset: begin
          next_state.rdata[opdec_pkg::ctrl_size_bit]   = state.default_size;
          next_state.rdata[opdec_pkg::ctrl_legacy_bit] = state.legacy_mode;
        end
        opdec_pkg::status_offset: begin
          next_state.rdata[opdec_pkg::status_op32_bit]    = state.res.op32;
          next_state.rdata[opdec_pkg::status_addr32_bit]  =
            state.res.addr32;
          next_state.rdata[opdec_pkg::status_bad_seg_bit] =
            state.bad_seg_seen;
        end
        opdec_pkg::count_offset: next_state.rdata = state.count;
        default: next_state.rdata = 32'h0;   // unmapped reads zero
      endcase
    end
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state              <= '0;
      state.default_size <= opdec_pkg::ctrl_size_reset;
      state.legacy_mode  <= opdec_pkg::ctrl_legacy_reset;
      state.count        <= opdec_pkg::count_reset;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops
  assign o_rdata     = state.rdata;
  assign o_res_valid = state.res_valid;
  assign o_res       = state.res;

endmodule

// ---- opdec_monitor.sv ----
`timescale 1ns/1ns
module opdec_monitor (
  // clock and reset
  input wire logic                    i_clk_sys,
  input wire logic                    i_rst,
  // register port
  input wire logic [7:0]              i_addr,
  input wire logic [31:0]             i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [31:0]             o_rdata,
  // decode request and result
  input wire logic                    i_req_valid,
  input wire opdec_pkg::dec_req_t     i_req,
  input wire logic                    o_res_valid,
  input wire opdec_pkg::dec_result_t  o_res
);
  // ********************************************************
  // timing of the two ports
  // ********************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_res_valid_follows: assert property (i_req_valid |=> o_res_valid)
    else $error("result valid missing after request");
  a_no_spurious_res: assert property (!i_req_valid |=> !o_res_valid)
    else $error("result valid without request");
  a_res_holds_idle: assert property (!i_req_valid |=> $stable(o_res))
    else $error("result changed without request");
  a_rdata_zero_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside read");

  // ********************************************************
  // field decoding, checked against the request one cycle back
  // ********************************************************
  a_seg2_decode: assert property (i_req_valid |=>
    o_res.seg2 == opdec_pkg::seg_t'({1'b0, $past(i_req.seg_sel_2bit)} + 3'h1))
    else $error("two bit segment selector decoded wrongly");
  a_seg3_decode: assert property (i_req_valid &&
    i_req.seg_sel_3bit <= opdec_pkg::seg3_last_good |=>
    o_res.seg3 == opdec_pkg::seg_t'($past(i_req.seg_sel_3bit) + 3'h1))
    else $error("three bit segment selector decoded wrongly");
  a_bad_seg_flag: assert property (i_req_valid |=>
    o_res.bad_seg == ($past(i_req.seg_sel_3bit) > 3'h5))
    else $error("reserved segment flag wrong");
  a_sib_only_32: assert property (i_req_valid && !i_req.implied_addr |=>
    o_res.sib_expected == (o_res.addr32 && $past(i_req.modrm[2:0]) == 3'h4
    && $past(i_req.modrm[7:6]) != 2'h3))
    else $error("sib expectation wrong");
  a_reg_direct: assert property (i_req_valid && !i_req.implied_addr &&
    i_req.modrm[7:6] == 2'h3 |=> o_res.rm_is_reg)
    else $error("mode 11 did not give a register operand");
  a_byte_select: assert property (i_req_valid && i_req.w_present &&
    !i_req.w && i_req.gpr_from_opcode |=> o_res.operand_reg ==
    opdec_pkg::gpr_t'(opdec_pkg::byte_first + {2'h0, $past(i_req.gpr_field)}))
    else $error("byte register selection wrong");
  a_direct_word: assert property (i_req_valid && !i_req.implied_addr &&
    i_req.modrm[7:6] == 2'h0 && i_req.modrm[2:0] == 3'h6 |=>
    !o_res.addr32 |-> o_res.disp == opdec_pkg::word_displacement)
    else $error("direct word displacement missing");

  c_bad_seg: cover property (o_res_valid && o_res.bad_seg);
  c_sib: cover property (o_res_valid && o_res.sib_expected);
  c_reg_direct: cover property (o_res_valid && o_res.rm_is_reg);
  c_back_to_back: cover property (i_req_valid [*3]);
endmodule

bind operand_addr_field_decoder opdec_monitor opdec_monitor_inst (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_res_valid(o_res_valid),
  .o_res(o_res));

// ---- test_operand_addr_field_decoder.sv ----
`timescale 1ns/1ns
module test_operand_addr_field_decoder;
  // ********************************************************
  // stimulus, design and bookkeeping
  // ********************************************************
  logic                   i_clk_sys = 1'b0;
  logic                   i_rst = 1'b1;
  logic [7:0]             i_addr = 8'h00;
  logic [31:0]            i_wdata = 32'h0;
  logic                   i_wr = 1'b0;
  logic                   i_rd = 1'b0;
  logic                   i_req_valid = 1'b0;
  opdec_pkg::dec_req_t    i_req = '0;
  logic [31:0]            o_rdata;
  logic                   o_res_valid;
  opdec_pkg::dec_result_t o_res;
  int                     mismatches = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  int                     ndec = 0;
  logic [1:0]             ctrl = 2'h0;
  logic [2:0]             status = 3'h0;
  opdec_pkg::dec_req_t    r;

  always #2 i_clk_sys = ~i_clk_sys;

  operand_addr_field_decoder operand_addr_field_decoder_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_req_valid(i_req_valid), .i_req(i_req),
    .o_res_valid(o_res_valid), .o_res(o_res));

  // ********************************************************
  // expectation and comparison helpers
  // ********************************************************
  function automatic opdec_pkg::gpr_t exp_gpr(logic wp, logic w, logic o32,
                                               logic [2:0] c);
    logic [4:0] first;
    first = (wp && !w) ? opdec_pkg::byte_first :
            o32 ? opdec_pkg::dword_first : opdec_pkg::word_first;
    return opdec_pkg::gpr_t'(first + {2'h0, c});
  endfunction

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // register reads compare in the cycle after the strobe, the only one
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    i_req_valid <= 1'b0;
    i_wr        <= 1'b0;
    i_rd        <= 1'b1;
    i_addr      <= a;
    @(posedge i_clk_sys);
    #1;
    check(n, e, o_rdata);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_req_valid <= 1'b0;
    i_rd        <= 1'b0;
    i_wr        <= 1'b1;
    i_addr      <= a;
    i_wdata     <= d;
    @(posedge i_clk_sys);
    #1;
    if (a == opdec_pkg::ctrl_offset) ctrl = d[1:0];
    if (a == opdec_pkg::status_offset && d[2]) status[2] = 1'b0;
  endtask

  // one request per call; calls may follow each other with no gap
  task automatic dec(opdec_pkg::dec_req_t q);
    logic o32, a32;
    logic [1:0] md;
    logic [2:0] rm, bc;
    opdec_pkg::gpr_t b, x, opr;
    opdec_pkg::disp_t d;
    i_wr        <= 1'b0;
    i_rd        <= 1'b0;
    i_req       <= q;
    i_req_valid <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    ndec++;
    o32 = (ctrl[0] & ~ctrl[1]) ^ q.opsize_prefix;
    a32 = (ctrl[0] & ~ctrl[1]) ^ q.addrsize_prefix;
    md = q.modrm[7:6];
    rm = q.modrm[2:0];
    status = {status[2] | (q.seg_sel_3bit > 3'h5), a32, o32};
    opr = q.gpr_from_opcode ? exp_gpr(q.w_present, q.w, o32, q.gpr_field) :
          q.reg_is_ext ? opdec_pkg::gpr_none :
          exp_gpr(q.w_present, q.w, o32, q.modrm[5:3]);
    check("res_valid", 1'b1, o_res_valid);
    check("op32", o32, o_res.op32);
    check("addr32", a32, o_res.addr32);
    check("operand_reg", opr, o_res.operand_reg);
    check("opcode_ext", (q.reg_is_ext && !q.gpr_from_opcode) ?
          q.modrm[5:3] : 3'h0, o_res.opcode_ext);
    check("seg2", {1'b0, q.seg_sel_2bit} + 3'h1, o_res.seg2);
    check("seg3", q.seg_sel_3bit > 3'h5 ? 3'h0 : q.seg_sel_3bit + 3'h1,
          o_res.seg3);
    check("bad_seg", q.seg_sel_3bit > 3'h5, o_res.bad_seg);
    if (q.implied_addr) begin
      check("implied_rm", 1'b0, o_res.rm_is_reg);
      check("implied_seg", opdec_pkg::seg_none, o_res.def_seg);
    end else begin
      check("sib", a32 && rm == 3'h4 && md != 2'h3, o_res.sib_expected);
      check("rm_is_reg", md == 2'h3, o_res.rm_is_reg);
      if (md == 2'h3) begin
        check("rm_reg", exp_gpr(q.w_present, q.w, o32, rm), o_res.rm_reg);
      end else if (!a32) begin
        // 16-bit form: the row is built from bit patterns of rm
        b = rm == 3'h7 ? opdec_pkg::base_word :
            rm == 3'h6 ? (md == 2'h0 ? opdec_pkg::gpr_none :
            opdec_pkg::frame_pointer_word) : rm[2] ? opdec_pkg::gpr_none :
            rm[1] ? opdec_pkg::frame_pointer_word : opdec_pkg::base_word;
        x = (rm[2] && rm[1]) ? opdec_pkg::gpr_none :
            rm[0] ? opdec_pkg::dest_index_word : opdec_pkg::source_index_word;
        d = md == 2'h1 ? opdec_pkg::short_displacement :
            (md == 2'h2 || rm == 3'h6) ? opdec_pkg::word_displacement :
            opdec_pkg::no_displacement;
        check("base16", b, o_res.base_reg);
        check("index16", x, o_res.index_reg);
        check("disp16", d, o_res.disp);
        check("seg16", b == opdec_pkg::frame_pointer_word ?
              opdec_pkg::stack_segment : opdec_pkg::data_segment,
              o_res.def_seg);
      end else begin
        // 32-bit form: the base code comes from sib when rm escapes
        bc = rm == 3'h4 ? q.sib[2:0] : rm;
        b = (md == 2'h0 && bc == 3'h5) ? opdec_pkg::gpr_none :
            exp_gpr(1'b1, 1'b1, 1'b1, bc);
        x = (rm != 3'h4 || q.sib[5:3] == 3'h4) ? opdec_pkg::gpr_none :
            exp_gpr(1'b1, 1'b1, 1'b1, q.sib[5:3]);
        d = md == 2'h1 ? opdec_pkg::short_displacement :
            (md == 2'h2 || b == opdec_pkg::gpr_none) ?
            opdec_pkg::dword_displacement : opdec_pkg::no_displacement;
        check("base32", b, o_res.base_reg);
        check("index32", x, o_res.index_reg);
        check("scale32", rm == 3'h4 ? q.sib[7:6] : 2'h0,
              o_res.scale);
        check("disp32", d, o_res.disp);
        check("seg32", (b == opdec_pkg::stack_pointer_dword ||
              b == opdec_pkg::frame_pointer_dword) ?
              opdec_pkg::stack_segment : opdec_pkg::data_segment,
              o_res.def_seg);
      end
    end
  endtask

  function automatic opdec_pkg::dec_req_t rand_req();
    opdec_pkg::dec_req_t q;
    q = opdec_pkg::dec_req_t'(31'($urandom));
    q.implied_addr = ($urandom_range(7) == 0);
    if (q.sib[5:3] == opdec_pkg::index_none) q.sib[7:6] = 2'h0;
    return q;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ********************************************************
  // hang guard and main sequence
  // ********************************************************
  // the run needs well under a thousand cycles; this leaves wide margin
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("[FAIL] timeout expected 0 seen %0d", cycles);
      final_report();
    end
  end

  initial begin
    void'($urandom(94614));
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    rd(opdec_pkg::ctrl_offset, 32'h0, "ctrl_reset");
    rd(opdec_pkg::status_offset, 32'h0, "status_reset");
    rd(opdec_pkg::count_offset, 32'h0, "count_reset");
    rd(8'h0c, 32'h0, "unmapped_read");
    wr(8'h10, 32'hffff_ffff);
    rd(opdec_pkg::ctrl_offset, 32'h0, "ctrl_unmapped_write");
    r = '0;
    r.modrm = 8'h46;
    dec(r);
    for (int c = 0; c < 4; c++) begin
      wr(opdec_pkg::ctrl_offset, 32'(c));
      rd(opdec_pkg::ctrl_offset, 32'(c), "ctrl");
      for (int k = 0; k < 8; k++) begin
        r = rand_req();
        r.seg_sel_3bit = 3'(k);
        r.seg_sel_2bit = 2'(k);
        dec(r);
      end
      repeat (100) dec(rand_req());
      rd(opdec_pkg::status_offset, {29'h0, status}, "status");
    end
    r = rand_req();
    r.seg_sel_3bit = 3'h7;
    dec(r);
    rd(opdec_pkg::status_offset, {29'h0, status}, "status_sticky");
    wr(opdec_pkg::status_offset, 32'h4);
    rd(opdec_pkg::status_offset, {29'h0, status}, "status_cleared");
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    check("rdata_idle", 32'h0, o_rdata);
    rd(opdec_pkg::count_offset, 32'(ndec), "count");
    final_report();
  end
endmodule
